// ==== pkg/ccpsp_pkg.sv ====
// Constants shared by the standard PWM unit and its helpers.
// Assumes a single system clock domain; no bus, all settings are ports.
package ccpsp_pkg;
	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int TMR_W = 8;
	localparam int DUTY_W = 10;
	localparam int SUB_W = 2;
	// ----------------------------------------
	// Codes, reset values and prescaler limits
	// ----------------------------------------
	localparam logic [3:0] FUNC_PWM = 4'hf;
	localparam logic [1:0] PRESC_1 = 2'h0;
	localparam logic [1:0] PRESC_4 = 2'h1;
	localparam logic [1:0] PRESC_16 = 2'h2;
	localparam logic [1:0] PRESC_64 = 2'h3;
	localparam logic [7:0] TMR_RST = 8'h00;
	localparam logic [9:0] DUTY_RST = 10'h000;
	localparam logic [5:0] PRE_RST = 6'h00;
	localparam logic [5:0] PRE_MAX_1 = 6'h00;
	localparam logic [5:0] PRE_MAX_4 = 6'h03;
	localparam logic [5:0] PRE_MAX_16 = 6'h0f;
	localparam logic [5:0] PRE_MAX_64 = 6'h3f;

	typedef enum logic [1:0] {
		CCPSP_IDLE = 2'b00,
		CCPSP_RUN = 2'b01,
		CCPSP_FROZEN = 2'b10
	} ccpsp_state_e;
endpackage

// ==== pkg/ccpsp_tb_if.sv ====
// Time base carrier between the timer helper and the PWM top.
// Assumes both ends on the same clock.
`timescale 1ns/100ps
interface ccpsp_tb_if;
	logic [9:0] time_base;
	logic [9:0] time_base_next;
	logic tick;
	logic period_end;
	logic [7:0] count;
	logic [7:0] period_limit;
	modport timer (output time_base, output time_base_next, output tick, output period_end,
		output count, input period_limit);
	modport pwm (input time_base, input time_base_next, input tick, input period_end,
		input count, output period_limit);
endinterface

// ==== verilog/ccpsp_timer.sv ====
// Period timer with prescaler, extended to a 10-bit time base.
// Assumes run and sleep are synchronous to clk.
`timescale 1ns/100ps
module ccpsp_timer (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic run,
	input wire logic sleep,
	input wire logic [1:0] timer_prescale_sel,
	ccpsp_tb_if.timer tb
);
	logic [5:0] pre_reg;
	logic [7:0] cnt_reg;
	logic [5:0] pre_max;
	logic go;
	logic pre_step;
	logic [5:0] pre_next;
	logic [7:0] cnt_next;
	logic [1:0] ph_reg;
	logic [1:0] ph_next;

	// Time base from count, phase and prescaler for the selected prescale
	function automatic logic [9:0] base_of(input logic [1:0] sel, input logic [7:0] cnt,
		input logic [1:0] ph, input logic [5:0] pre);
		case (sel)
			ccpsp_pkg::PRESC_1: base_of = {cnt, ph};
			ccpsp_pkg::PRESC_4: base_of = {cnt, pre[1:0]};
			ccpsp_pkg::PRESC_16: base_of = {cnt, pre[3:2]};
			default: base_of = {cnt, pre[5:4]};
		endcase
	endfunction

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	always_comb begin
		case (timer_prescale_sel)
			ccpsp_pkg::PRESC_1: pre_max = ccpsp_pkg::PRE_MAX_1;
			ccpsp_pkg::PRESC_4: pre_max = ccpsp_pkg::PRE_MAX_4;
			ccpsp_pkg::PRESC_16: pre_max = ccpsp_pkg::PRE_MAX_16;
			default: pre_max = ccpsp_pkg::PRE_MAX_64;
		endcase
	end

	assign go = run && !sleep;
	// Prescaler steps once per four clocks, so the timer period carries the factor four
	assign pre_step = go && (ph_reg == 2'h3);
	assign pre_next = !pre_step ? pre_reg : (pre_reg >= pre_max) ? ccpsp_pkg::PRE_RST
		: pre_reg + 6'h01;
	assign ph_next = go ? ph_reg + 2'h1 : ph_reg;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_reg <= ccpsp_pkg::PRE_RST;
		end else begin
			pre_reg <= pre_next;
		end
	end

	// ----------------------------------------
	// Timer count, cleared after match
	// ----------------------------------------
	assign tb.tick = pre_step && (pre_reg >= pre_max);
	assign tb.period_end = tb.tick && (cnt_reg == tb.period_limit);
	assign cnt_next = tb.period_end ? ccpsp_pkg::TMR_RST
		: tb.tick ? cnt_reg + 8'h01 : cnt_reg;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= ccpsp_pkg::TMR_RST;
		end else if (tb.period_end) begin
			cnt_reg <= ccpsp_pkg::TMR_RST;
		end else if (tb.tick) begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

	// Clock-cycle counter stands in for the two oscillator phase bits at 1:1
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ph_reg <= 2'h0;
		end else begin
			ph_reg <= ph_next;
		end
	end

	// Next value lets the registered pin clear on the edge the base reaches the duty
	always_comb begin
		tb.time_base = base_of(timer_prescale_sel, cnt_reg, ph_reg, pre_reg);
		tb.time_base_next = base_of(timer_prescale_sel, cnt_next, ph_next, pre_next);
	end
	assign tb.count = cnt_reg;
endmodule

// ==== verilog/ccpsp_duty.sv ====
// Duty value unpacking by alignment select.
// Assumes the two duty bytes are held by the caller.
`timescale 1ns/100ps
module ccpsp_duty (
	input wire logic duty_align_sel,
	input wire logic [7:0] duty_low_reg,
	input wire logic [7:0] duty_high_reg,
	output logic [9:0] pulse_width_value
);
	always_comb begin
		if (duty_align_sel) begin
			pulse_width_value = {duty_high_reg, duty_low_reg[7:6]};
		end else begin
			pulse_width_value = {duty_high_reg[1:0], duty_low_reg};
		end
	end
endmodule

// ==== verilog/ccpsp_pwm.sv ====
// Standard PWM unit: period timer, double-buffered duty, waveform pin.
// Assumes settings ports are synchronous to clk and stable from software.
`timescale 1ns/100ps
module ccpsp_pwm (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic unit_enable,
	input wire logic [3:0] function_select,
	input wire logic duty_align_sel,
	input wire logic [7:0] duty_low_reg,
	input wire logic [7:0] duty_high_reg,
	input wire logic [7:0] period_limit,
	input wire logic [1:0] timer_prescale_sel,
	input wire logic timer_run,
	input wire logic sleep,
	input wire logic pin_direction,
	output logic waveform_pin_out,
	output logic waveform_pin_oe,
	output logic waveform_level,
	output logic timer_match_flag,
	output logic [7:0] period_timer_count,
	output logic [9:0] duty_buffer,
	output logic pwm_active
);
	// ----------------------------------------
	// Mode and state
	// ----------------------------------------
	ccpsp_tb_if tb ();
	ccpsp_pkg::ccpsp_state_e state_reg;
	ccpsp_pkg::ccpsp_state_e state_next;
	logic pwm_mode;
	logic [9:0] duty_raw;
	logic [9:0] buf_reg;
	logic out_reg;
	logic flag_reg;
	logic set_ok;

	assign pwm_mode = unit_enable && (function_select == ccpsp_pkg::FUNC_PWM);

	always_comb begin
		case (state_reg)
			ccpsp_pkg::CCPSP_IDLE: state_next = pwm_mode ? ccpsp_pkg::CCPSP_RUN
				: ccpsp_pkg::CCPSP_IDLE;
			ccpsp_pkg::CCPSP_RUN: begin
				if (!pwm_mode) begin
					state_next = ccpsp_pkg::CCPSP_IDLE;
				end else if (sleep) begin
					state_next = ccpsp_pkg::CCPSP_FROZEN;
				end else begin
					state_next = ccpsp_pkg::CCPSP_RUN;
				end
			end
			ccpsp_pkg::CCPSP_FROZEN: begin
				if (!pwm_mode) begin
					state_next = ccpsp_pkg::CCPSP_IDLE;
				end else if (sleep) begin
					state_next = ccpsp_pkg::CCPSP_FROZEN;
				end else begin
					state_next = ccpsp_pkg::CCPSP_RUN;
				end
			end
			default: state_next = ccpsp_pkg::CCPSP_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ccpsp_pkg::CCPSP_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// Time base
	// ----------------------------------------
	// No postscaler exists here, so period timing cannot depend on one
	ccpsp_timer u_timer (
		.clk(clk),
		.rst_b(rst_b),
		.run(timer_run),
		.sleep(sleep),
		.timer_prescale_sel(timer_prescale_sel),
		.tb(tb.timer)
	);
	assign tb.period_limit = period_limit;

	ccpsp_duty u_duty (
		.duty_align_sel(duty_align_sel),
		.duty_low_reg(duty_low_reg),
		.duty_high_reg(duty_high_reg),
		.pulse_width_value(duty_raw)
	);

	// ----------------------------------------
	// Duty buffer
	// ----------------------------------------
	// Bytes are live; only this buffer reaches the comparator, avoiding glitches
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			buf_reg <= ccpsp_pkg::DUTY_RST;
		end else if (tb.period_end) begin
			buf_reg <= duty_raw;
		end
	end

	// ----------------------------------------
	// Output level
	// ----------------------------------------
	// Duty beyond the period never matches, so the level simply holds
	assign set_ok = (duty_raw != ccpsp_pkg::DUTY_RST);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			out_reg <= 1'b0;
		end else if (!pwm_mode) begin
			out_reg <= 1'b0;
		end else if (tb.period_end) begin
			out_reg <= set_ok;
		end else if ((tb.time_base_next == buf_reg) && (tb.time_base != buf_reg)) begin
			// Only the arrival clears, so a frozen base in sleep holds the level
			out_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Match flag, one-cycle pulse registered from period end
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= tb.period_end;
		end
	end

	assign waveform_level = out_reg;
	assign waveform_pin_out = out_reg;
	assign waveform_pin_oe = pwm_mode && !pin_direction;
	assign timer_match_flag = flag_reg;
	assign period_timer_count = tb.count;
	assign duty_buffer = buf_reg;
	assign pwm_active = (state_reg == ccpsp_pkg::CCPSP_RUN);
endmodule

// ==== verif/ccpsp_load.sv ====
// External load on the waveform pin: counts high and total cycles.
// Assumes a pull-down holds the pin low whenever the unit releases it.
`timescale 1ns/100ps
module ccpsp_load (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic drv,
	input wire logic oe,
	output logic [15:0] hi_cnt,
	output logic [15:0] all_cnt
);
	// Released pin reads low, never the last driven level
	wire logic pin = oe ? drv : 1'b0;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hi_cnt <= 16'h0;
			all_cnt <= 16'h0;
		end else begin
			hi_cnt <= hi_cnt + 16'(pin);
			all_cnt <= all_cnt + 16'h1;
		end
	end
endmodule

// ==== verif/ccpsp_pwm_props.sv ====
// Concurrent checks on the standard PWM unit's ports.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/100ps
module ccpsp_pwm_props (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] function_select,
	input wire logic pin_direction,
	input wire logic sleep,
	input wire logic waveform_pin_out,
	input wire logic waveform_pin_oe,
	input wire logic waveform_level,
	input wire logic timer_match_flag,
	input wire logic [7:0] period_timer_count,
	input wire logic [9:0] duty_buffer
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	chk_oe_mode: assert property (waveform_pin_oe |-> !pin_direction
		&& function_select == ccpsp_pkg::FUNC_PWM) else $error("pin driven out of mode");
	chk_flag_pulse: assert property (timer_match_flag |=> !timer_match_flag)
		else $error("match flag longer than one cycle");
	chk_flag_wrap: assert property (timer_match_flag |-> period_timer_count == 8'h00)
		else $error("match flag without timer clear");
	chk_sleep_hold: assert property (sleep |=> $stable(period_timer_count)
		&& $stable(duty_buffer) && $stable(waveform_level)) else $error("state moved in sleep");
	chk_buf_load: assert property ($changed(duty_buffer) |-> period_timer_count == 8'h00)
		else $error("duty buffer loaded mid period");
	chk_rise_start: assert property ($rose(waveform_level) |->
		period_timer_count == 8'h00 && duty_buffer != 10'h000) else $error("bad pin rise");
	chk_off_mode: assert property ((function_select != ccpsp_pkg::FUNC_PWM)[*2]
		|-> !waveform_pin_out) else $error("pin high out of mode");
	chk_count_step: assert property ($changed(period_timer_count) |->
		period_timer_count == $past(period_timer_count) + 8'h01 || period_timer_count == 8'h00)
		else $error("timer skipped a count");
	cover property ($rose(waveform_level));
	cover property (timer_match_flag && duty_buffer == 10'h000);
	cover property (sleep ##1 sleep);
endmodule
bind ccpsp_pwm ccpsp_pwm_props ccpsp_pwm_props_i (.clk, .rst_b, .function_select,
	.pin_direction, .sleep, .waveform_pin_out, .waveform_pin_oe, .waveform_level,
	.timer_match_flag, .period_timer_count, .duty_buffer);

// ==== verif/ccpsp_pwm_tb.sv ====
// Self-checking bench for the standard PWM unit with a load on its pin.
// Assumes the checker is bound in its own file.
`timescale 1ns/100ps
module ccpsp_pwm_tb;
	logic clk, rst_b, run, slp, dir, algn, out, oe, lvl, flag, act, l0;
	logic [3:0] fsel;
	logic [7:0] lo, hi, lim, cnt;
	logic [1:0] ps;
	logic [9:0] dbuf;
	logic [15:0] hc, ac, h0, a0;
	int bad_count = 0;
	int n_tests = 0;
	int seed = 32'h69658971;
	int i;
	ccpsp_pwm ccpsp_pwm_i (.clk(clk), .rst_b(rst_b), .unit_enable(1'b1), .function_select(fsel),
		.duty_align_sel(algn), .duty_low_reg(lo), .duty_high_reg(hi), .period_limit(lim),
		.timer_prescale_sel(ps), .timer_run(run), .sleep(slp), .pin_direction(dir),
		.waveform_pin_out(out), .waveform_pin_oe(oe), .waveform_level(lvl),
		.timer_match_flag(flag), .period_timer_count(cnt), .duty_buffer(dbuf), .pwm_active(act));
	ccpsp_load ccpsp_load_i (.clk(clk), .rst_b(rst_b), .drv(out), .oe(oe), .hi_cnt(hc),
		.all_cnt(ac));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		return $random(seed);
	endfunction
	task automatic wrap_up;
		$display("tests %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %0d expected %0d", $time, got, exp);
		end
	endtask
	// Bounded wait; a lost flag ends the run
	task automatic wflag;
		int k;
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (flag !== 1'b1 && k < 6000);
		if (k >= 6000) begin
			bad_count++;
			$display("BAD %0t match flag never came", $time);
			wrap_up;
		end
	endtask
	// Settings change right after a flag, so the count never overshoots the limit
	task automatic run_case(input logic [9:0] d, input logic [7:0] l, input logic [1:0] p,
		input logic a);
		logic [15:0] per, w;
		per = (16'(l) + 16'h1) << (2 + 2 * p);
		w = 16'(d) << (2 * p);
		wflag;
		@(posedge clk);
		lim <= l;
		ps <= p;
		algn <= a;
		lo <= a ? {d[1:0], 6'(rnd())} : d[7:0];
		hi <= a ? d[9:2] : {6'(rnd()), d[9:8]};
		repeat (3) wflag;
		h0 = hc;
		a0 = ac;
		wflag;
		chk(ac - a0, per);
		chk(hc - h0, w > per ? per : w);
		chk({15'h0, act}, 16'h1);
		$display("case duty %0d limit %0d presc %0d done", d, l, p);
	endtask
	initial begin
		rst_b = 1'b0;
		run = 1'b0;
		slp = 1'b0;
		dir = 1'b1;
		algn = 1'b0;
		fsel = ccpsp_pkg::FUNC_PWM;
		lo = 8'h02;
		hi = 8'h00;
		lim = 8'h03;
		ps = ccpsp_pkg::PRESC_1;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		run <= 1'b1;
		wflag;
		chk({15'h0, oe}, 16'h0);
		@(posedge clk);
		dir <= 1'b0;
		run_case(10'h000, 8'h03, ccpsp_pkg::PRESC_1, 1'b0);
		run_case(10'h3ff, 8'h02, ccpsp_pkg::PRESC_4, 1'b1);
		run_case(10'h3ff, 8'hff, ccpsp_pkg::PRESC_1, 1'b0);
		run_case(10'h001, 8'h00, ccpsp_pkg::PRESC_64, 1'b1);
		for (i = 0; i < 8; i++) begin
			run_case(10'(6'(rnd())), 8'(3'(rnd())), 2'(i), i[0]);
		end
		@(posedge clk);
		slp <= 1'b1;
		repeat (5) @(posedge clk);
		#1;
		h0 = {6'h00, dbuf};
		a0 = {8'h00, cnt};
		l0 = lvl;
		repeat (30) @(posedge clk);
		#1;
		chk({8'h00, cnt}, a0);
		chk({14'h0, act, lvl}, {15'h0, l0});
		chk({6'h00, dbuf}, h0);
		@(posedge clk);
		slp <= 1'b0;
		fsel <= 4'h0;
		repeat (3) @(posedge clk);
		#1;
		chk({14'h0, out, oe}, 16'h0);
		$display("sleep and mode case done");
		wrap_up;
	end
endmodule
